// file: src/tlpt_pkg.sv
// Package for the test loop and packet test mode controller.
package tlpt_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] TLPT_OFS_CTRL   = 8'h00;
   localparam logic [7:0] TLPT_OFS_CMD    = 8'h04;
   localparam logic [7:0] TLPT_OFS_PDUCNT = 8'h08;
   localparam logic [7:0] TLPT_OFS_TSCFG  = 8'h0c;
   localparam logic [7:0] TLPT_OFS_STATUS = 8'h10;
   localparam logic [7:0] TLPT_OFS_EVENT  = 8'h14;
   localparam logic [7:0] TLPT_OFS_SENT   = 8'h18;
   localparam logic [7:0] TLPT_OFS_PRBS   = 8'h1c;

   // ****************************************************************
   // Field positions and values
   // ****************************************************************
   localparam int          TLPT_CTRL_CAP_A_BIT   = 0;
   localparam int          TLPT_CTRL_CAP_B_BIT   = 1;
   localparam int          TLPT_CTRL_MAP_EN_BIT  = 2;
   localparam logic [3:0]  TLPT_CMD_CLOSE_SINGLE = 4'h1;
   localparam logic [3:0]  TLPT_CMD_CLOSE_MULTI  = 4'h2;
   localparam logic [3:0]  TLPT_CMD_OPEN_SINGLE  = 4'h3;
   localparam logic [3:0]  TLPT_CMD_OPEN_MULTI   = 4'h4;
   localparam logic [3:0]  TLPT_CMD_TEST_MODE    = 4'h5;
   localparam logic [3:0]  TLPT_CMD_DL_RELEASE   = 4'h6;
   localparam logic [3:0]  TLPT_CMD_UL_RELEASE   = 4'h7;
   localparam logic [3:0]  TLPT_CMD_TBF_GRANT    = 4'h8;
   localparam int          TLPT_CMD_TYPEC_BIT    = 4;
   localparam int          TLPT_CMD_LOOPB_BIT    = 5;
   localparam logic [3:0]  TLPT_CV_HOLD          = 4'hf;
   localparam logic [14:0] TLPT_PRBS_SEED        = 15'h7fff;
   localparam logic [7:0]  TLPT_ACK_BIT0         = 8'h01;

   typedef enum logic [2:0] {
      TLPT_IDLE, TLPT_SLOOP, TLPT_MLOOP, TLPT_REQ, TLPT_MODE_A, TLPT_MODE_B
   } tlpt_state_e;

   // Uplink block descriptor handed to the radio layer.
   typedef struct packed {
      logic        valid;
      logic [2:0]  tn;
      logic [3:0]  cv;
      logic        prbs;
      logic        data_bit;
   } tlpt_ul_s;

   // Downlink bit stream from the receiver.
   typedef struct packed {
      logic        valid;
      logic [2:0]  tn;
      logic        data_bit;
      logic        ctrl_blk;
      logic        usf_ok;
   } tlpt_dl_s;

endpackage : tlpt_pkg

// file: src/tlpt_ctrl.sv
// Test loop and packet test mode controller with AHB-Lite registers.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module tlpt_ctrl (
   input  wire  logic                  hclk,       // Bus clock.
   input  wire  logic                  hresetn,    // Async reset.
   input  wire  logic                  hsel,       // Slave select.
   input  wire  logic [7:0]            haddr,      // Byte address.
   input  wire  logic [1:0]            htrans,     // Transfer type.
   input  wire  logic                  hwrite,     // Write.
   input  wire  logic [2:0]            hsize,      // Size.
   input  wire  logic [31:0]           hwdata,     // Write data.
   input  wire  logic                  hready,     // Bus ready.
   output logic [31:0]                 hrdata,     // Read data.
   output logic                        hreadyout,  // Slave ready.
   output logic                        hresp,      // Always OKAY.
   input  wire  tlpt_pkg::tlpt_dl_s    dl_in,      // Downlink bits.
   input  wire  logic                  ul_slot,    // Uplink bit slot.
   input  wire  logic [2:0]            ul_tn,      // Uplink timeslot.
   input  wire  logic                  pdu_done,   // Uplink PDU sent.
   output tlpt_pkg::tlpt_ul_s          ul_out,     // Uplink bit.
   output logic                        llc_pass,   // Data to LLC.
   output logic                        tbf_req,    // Uplink TBF req.
   output logic                        ack_single, // Open ack pulse.
   output logic [7:0]                  ack_elem,   // Ack element.
   output logic                        ack_multi,  // Multi ack pulse.
   output logic                        loop_on     // Loop closed.
);
   import tlpt_pkg::*;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [2:0]  ctrl_q;
   logic [15:0] pdu_cnt_q;
   logic [15:0] sent_q;
   logic [2:0]  dl_ofs_q;
   logic [7:0]  dl_act_q;
   logic        typec_q;
   logic        mode_b_q;
   logic [14:0] prbs_q;
   tlpt_state_e st_q;
   logic [7:0]  ev_q;
   logic [7:0]  slot_buf_q [8];
   logic [7:0]  last_q;

   wire acc = hsel & hready & htrans[1];
   wire cmd_wr = wr_pend_q && (wr_addr_q == TLPT_OFS_CMD);
   wire [3:0] cmd = hwdata[3:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= acc & hwrite;
         wr_addr_q <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q    <= 3'h3;
         pdu_cnt_q <= 16'h0000;
         dl_ofs_q  <= 3'h0;
         dl_act_q  <= 8'h01;
      end else if (wr_pend_q) begin
         if (wr_addr_q == TLPT_OFS_CTRL) begin
            ctrl_q <= hwdata[2:0];
         end else if (wr_addr_q == TLPT_OFS_PDUCNT) begin
            pdu_cnt_q <= hwdata[15:0];
         end else if (wr_addr_q == TLPT_OFS_TSCFG) begin
            dl_ofs_q <= hwdata[2:0];
            dl_act_q <= hwdata[15:8];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc && !hwrite) begin
            if (haddr == TLPT_OFS_CTRL) begin
               hrdata <= {29'h0, ctrl_q};
            end else if (haddr == TLPT_OFS_PDUCNT) begin
               hrdata <= {16'h0, pdu_cnt_q};
            end else if (haddr == TLPT_OFS_TSCFG) begin
               hrdata <= {16'h0, dl_act_q, 5'h0, dl_ofs_q};
            end else if (haddr == TLPT_OFS_STATUS) begin
               hrdata <= {26'h0, mode_b_q, typec_q, 1'b0, st_q};
            end else if (haddr == TLPT_OFS_EVENT) begin
               hrdata <= {24'h0, ev_q};
            end else if (haddr == TLPT_OFS_SENT) begin
               hrdata <= {16'h0, sent_q};
            end else if (haddr == TLPT_OFS_PRBS) begin
               hrdata <= {17'h0, prbs_q};
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   // ****************************************************************
   // Loop and test mode sequencer
   // ****************************************************************
   // Chooses mode b only when the station declares loopback capability.
   function automatic logic pick_b(input logic [2:0] c, input logic m);
      pick_b = c[TLPT_CTRL_CAP_B_BIT] &
               (!c[TLPT_CTRL_CAP_A_BIT] | m);
   endfunction : pick_b

   wire test_on = (st_q == TLPT_MODE_A) || (st_q == TLPT_MODE_B)
                  || (st_q == TLPT_REQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q       <= TLPT_IDLE;
         typec_q    <= 1'b0;
         mode_b_q   <= 1'b0;
         ack_single <= 1'b0;
         ack_multi  <= 1'b0;
         ack_elem   <= 8'h00;
         ev_q       <= 8'h00;
      end else begin
         ack_single <= 1'b0;
         ack_multi  <= 1'b0;
         if (cmd_wr) begin
            case (st_q)
               TLPT_IDLE: begin
                  if (cmd == TLPT_CMD_CLOSE_SINGLE) begin
                     st_q    <= TLPT_SLOOP;
                     typec_q <= hwdata[TLPT_CMD_TYPEC_BIT];
                  end else if (cmd == TLPT_CMD_CLOSE_MULTI) begin
                     st_q <= TLPT_MLOOP;
                  end else if (cmd == TLPT_CMD_TEST_MODE) begin
                     st_q     <= TLPT_REQ;
                     mode_b_q <= pick_b(ctrl_q,
                                  hwdata[TLPT_CMD_LOOPB_BIT]);
                  end
                  // Open commands fall through here.
               end
               TLPT_SLOOP: begin
                  if (cmd == TLPT_CMD_OPEN_SINGLE) begin
                     st_q       <= TLPT_IDLE;
                     ack_single <= typec_q;
                     ack_elem   <= typec_q ? TLPT_ACK_BIT0 : 8'h00;
                  end
               end
               TLPT_MLOOP: begin
                  if (cmd == TLPT_CMD_OPEN_MULTI) begin
                     st_q      <= TLPT_IDLE;
                     ack_multi <= 1'b1;
                  end
               end
               TLPT_REQ: begin
                  if (cmd == TLPT_CMD_TBF_GRANT) begin
                     st_q <= mode_b_q ? TLPT_MODE_B : TLPT_MODE_A;
                  end
               end
               TLPT_MODE_A: begin
                  if (cmd == TLPT_CMD_UL_RELEASE ||
                      cmd == TLPT_CMD_DL_RELEASE) begin
                     st_q <= TLPT_IDLE;
                  end
               end
               TLPT_MODE_B: begin
                  if (cmd == TLPT_CMD_UL_RELEASE ||
                      cmd == TLPT_CMD_DL_RELEASE) begin
                     st_q <= TLPT_IDLE;
                  end
               end
               default: st_q <= TLPT_IDLE;
            endcase
         end else if (st_q == TLPT_MODE_A && sent_q >= pdu_cnt_q) begin
            st_q <= TLPT_IDLE;
         end
         ev_q <= {2'b0, ack_multi, ack_single, 4'h0} | ev_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sent_q <= 16'h0000;
      end else if (st_q == TLPT_REQ) begin
         sent_q <= 16'h0000;
      end else if (st_q == TLPT_MODE_A && pdu_done) begin
         sent_q <= sent_q + 16'h0001;
      end
   end

   // ****************************************************************
   // Payload generation and loopback
   // ****************************************************************
   // x^15 + x^14 + 1, period 32767.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prbs_q <= TLPT_PRBS_SEED;
      end else if (st_q == TLPT_REQ) begin
         prbs_q <= TLPT_PRBS_SEED;
      end else if (ul_slot && test_on) begin
         prbs_q <= {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]};
      end
   end

   // Counts a downlink slot's position from the offset with wrap.
   function automatic logic [2:0] dl_index(input logic [2:0] tn,
                                           input logic [2:0] ofs,
                                           input logic [7:0] act);
      logic [2:0] n;
      logic [2:0] k;
      n = 3'h0;
      k = ofs;
      for (int i = 0; i < 8; i++) begin
         if (k == tn) begin
            break;
         end
         if (act[k]) begin
            n = n + 3'h1;
         end
         k = k + 3'h1;
      end
      dl_index = n;
   endfunction : dl_index

   wire [2:0] dl_pos = dl_index(dl_in.tn, dl_ofs_q, dl_act_q);
   wire multi_dl = (dl_act_q & (dl_act_q - 8'h01)) != 8'h00;

   // Data blocks, even with a bad CRC, are kept when USF decodes.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_q <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            slot_buf_q[i] <= 8'h00;
         end
      end else if (st_q == TLPT_MODE_B && dl_in.valid && dl_in.usf_ok
                   && !dl_in.ctrl_blk) begin
         slot_buf_q[dl_pos] <= {slot_buf_q[dl_pos][6:0], dl_in.data_bit};
         last_q             <= {5'h00, dl_pos};
      end
   end

   wire [2:0] map_tn = (ul_tn > last_q[2:0]) ? last_q[2:0] : ul_tn;
   wire       map_en = ctrl_q[TLPT_CTRL_MAP_EN_BIT] & multi_dl;
   wire [2:0] src_tn = map_en ? map_tn : 3'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ul_out   <= '0;
         llc_pass <= 1'b1;
         tbf_req  <= 1'b0;
         loop_on  <= 1'b0;
      end else begin
         llc_pass <= !test_on;
         tbf_req  <= (st_q == TLPT_REQ);
         loop_on  <= (st_q == TLPT_SLOOP) || (st_q == TLPT_MLOOP);
         ul_out.valid <= ul_slot &&
                         (st_q == TLPT_MODE_A || st_q == TLPT_MODE_B);
         ul_out.tn    <= ul_tn;
         ul_out.cv    <= TLPT_CV_HOLD;
         ul_out.prbs  <= prbs_q[14];
         ul_out.data_bit <= (st_q == TLPT_MODE_B) ?
                            slot_buf_q[src_tn][7] :
                            prbs_q[14];
      end
   end

   AST_MULTI_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
      ack_multi |-> $past(st_q) == TLPT_MLOOP)
      else $error("Multi ack without closed loop.");
   AST_SINGLE_IGN: assert property (@(posedge hclk) disable iff (!hresetn)
      ack_single |-> $past(st_q) == TLPT_SLOOP && ack_elem[0])
      else $error("Single ack without closed type C loop.");
   AST_LLC: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == TLPT_MODE_B) |=> !llc_pass)
      else $error("Data passed to LLC during test.");
   AST_CV: assert property (@(posedge hclk) disable iff (!hresetn)
      ul_out.valid |-> ul_out.cv == 4'hf)
      else $error("Countdown value not held.");
   AST_PRBS_NZ: assert property (@(posedge hclk) disable iff (!hresetn)
      prbs_q != 15'h0000)
      else $error("Generator locked at zero.");
   AST_REQ: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == TLPT_REQ) |=> tbf_req)
      else $error("No uplink request in request state.");
   AST_SEED: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == TLPT_REQ) |=> prbs_q == 15'h7fff)
      else $error("Generator not seeded on entry.");
   AST_END_A: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == TLPT_MODE_A && !cmd_wr && sent_q >= pdu_cnt_q)
      |=> st_q == TLPT_IDLE)
      else $error("Mode a did not end on count.");

endmodule : tlpt_ctrl

// file: tb/tlpt_sim.sv
// Radio-side test system simulator model for the loop controller bench.
`timescale 1ns/1ps

module tlpt_sim (
   input  wire tlpt_pkg::tlpt_ul_s ul_out,   // Uplink bit from the block.
   input  wire logic               hclk,     // Clock.
   output tlpt_pkg::tlpt_dl_s      dl_in,    // Downlink bit stream.
   output logic                    ul_slot,  // Uplink bit request.
   output logic [2:0]              ul_tn,    // Uplink timeslot.
   output logic                    pdu_done  // Uplink PDU finished.
);
   import tlpt_pkg::*;

   logic [14:0] lfsr_q = 15'h1234;
   logic        dq[$];
   tlpt_ul_s    uq[$];

   initial begin
      dl_in    = '0;
      ul_slot  = 1'b0;
      ul_tn    = 3'h0;
      pdu_done = 1'b0;
   end

   // Uplink bits are collected at the falling edge where they have settled.
   always @(negedge hclk) begin
      if (ul_out.valid === 1'b1) begin
         uq.push_back(ul_out);
      end
   end

   // Downlink payload is pseudorandom; a released line shows inverted data.
   task automatic send_dl(input int n, input logic [2:0] tn);
      dq.delete();
      for (int i = 0; i < n; i++) begin
         dl_in <= '{1'b1, tn, lfsr_q[0], 1'b0, 1'b1};
         dq.push_back(lfsr_q[0]);
         lfsr_q = {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
         @(posedge hclk);
      end
      dl_in <= '{1'b0, ~tn, ~dq[n-1], 1'b0, 1'b0};
      @(posedge hclk);
   endtask : send_dl

   task automatic ask_ul(input int n, input logic [2:0] tn);
      for (int i = 0; i < n; i++) begin
         ul_slot <= 1'b1;
         ul_tn   <= tn;
         @(posedge hclk);
         ul_slot <= 1'b0;
         ul_tn   <= ~tn;
         @(posedge hclk);
      end
   endtask : ask_ul

   task automatic pdus(input int n);
      for (int i = 0; i < n; i++) begin
         pdu_done <= 1'b1;
         @(posedge hclk);
         pdu_done <= 1'b0;
         @(posedge hclk);
      end
   endtask : pdus

endmodule : tlpt_sim

// file: tb/tlpt_ctrl_bench.sv
// Self-checking bench for the test loop and packet test mode controller.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
   bad_count++; $display("mismatch at %0t got %h exp %h", $time, got, exp);\
   end end

module tlpt_ctrl_bench;
   import tlpt_pkg::*;

   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hresp, hreadyout, ul_slot, pdu_done;
   logic llc_pass, tbf_req, ack_single, ack_multi, loop_on, as, am;
   logic [7:0]  haddr, ack_elem, ae;
   logic [1:0]  htrans;
   logic [2:0]  hsize, ul_tn, tn;
   logic [31:0] hwdata, hrdata, rd, cnt;
   logic [3:0]  rels[2] = '{TLPT_CMD_DL_RELEASE, TLPT_CMD_UL_RELEASE};
   tlpt_dl_s    dl_in;
   tlpt_ul_s    ul_out;
   int          bad_count = 0;
   int          comparisons = 0;
   int          seed = 32'h552a;
   int          n;

   always #4 hclk = ~hclk;

   tlpt_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .dl_in(dl_in),
      .ul_slot(ul_slot), .ul_tn(ul_tn), .pdu_done(pdu_done),
      .ul_out(ul_out), .llc_pass(llc_pass), .tbf_req(tbf_req),
      .ack_single(ack_single), .ack_elem(ack_elem),
      .ack_multi(ack_multi), .loop_on(loop_on));

   tlpt_sim sim (.ul_out(ul_out), .hclk(hclk), .dl_in(dl_in),
      .ul_slot(ul_slot), .ul_tn(ul_tn), .pdu_done(pdu_done));

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // One single-word transfer; entered just after a rising edge.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsel   <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         k = 0;
         do begin
            @(posedge hclk);
            k++;
         end while (hreadyout !== 1'b1 && k < 100);
         if (k >= 100) begin
            bad_count++;
            print_verdict();
         end
         if (p == 0) begin
            htrans <= 2'b00;
            hsel   <= 1'b0;
            hwdata <= d;
         end
      end
      r = hrdata;
   endtask : bus

   // Samples the one-cycle pulses just after the updating edge, then
   // waits one more edge so the registered levels have followed.
   task automatic cmd(input logic [3:0] op, input logic [1:0] fl);
      bus(1'b1, TLPT_OFS_CMD, {26'h0, fl, op}, rd);
      #1;
      as = ack_single;
      am = ack_multi;
      ae = ack_elem;
      @(posedge hclk);
      #1;
   endtask : cmd

   task automatic chk_state(input logic [2:0] s);
      bus(1'b0, TLPT_OFS_STATUS, 32'h0, rd);
      `CHK(rd[2:0], s)
   endtask : chk_state

   // Uplink test bits must follow one fifteen-stage recurrence.
   task automatic prbs_check;
      int e1, e2, ones, zeros, k;
      e1 = 0; e2 = 0; ones = 0; zeros = 0; k = sim.uq.size();
      `CHK(k, 40)
      for (int i = 0; i < k; i++) begin
         ones += (sim.uq[i].prbs === 1'b1);
         zeros += (sim.uq[i].prbs === 1'b0);
         if (i >= 15) begin
            e1 += sim.uq[i].prbs ^ sim.uq[i-14].prbs ^ sim.uq[i-15].prbs;
            e2 += sim.uq[i].prbs ^ sim.uq[i-1].prbs ^ sim.uq[i-15].prbs;
         end
      end
      `CHK(ones + zeros, k)
      `CHK(ones > 0 && zeros > 0 && (e1 == 0 || e2 == 0), 1'b1)
      `CHK(sim.uq[k-1].tn, tn)
      sim.uq.delete();
   endtask : prbs_check

   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      print_verdict();
   end

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK(llc_pass, 1'b1)
      bus(1'b0, TLPT_OFS_CTRL, 32'h0, rd);
      `CHK(rd, 32'h3)
      bus(1'b0, TLPT_OFS_TSCFG, 32'h0, rd);
      `CHK(rd, 32'h100)
      bus(1'b0, 8'h40, 32'h0, rd);
      `CHK({hresp, rd}, 33'h0)
      cmd(TLPT_CMD_OPEN_SINGLE, 2'b00);
      `CHK({as, am}, 2'b00)
      cmd(TLPT_CMD_OPEN_MULTI, 2'b00);
      `CHK({as, am}, 2'b00)
      chk_state(3'h0);
      for (int tc = 0; tc < 2; tc++) begin
         cmd(TLPT_CMD_CLOSE_SINGLE, {1'b0, tc[0]});
         `CHK(loop_on, 1'b1)
         cmd(TLPT_CMD_OPEN_SINGLE, 2'b00);
         `CHK(as, tc[0])
         if (tc == 1) `CHK(ae, TLPT_ACK_BIT0)
         `CHK(loop_on, 1'b0)
         chk_state(3'h0);
      end
      cmd(TLPT_CMD_CLOSE_MULTI, 2'b00);
      chk_state(3'h2);
      cmd(TLPT_CMD_OPEN_MULTI, 2'b00);
      `CHK(am, 1'b1)
      chk_state(3'h0);
      // The PDU count is written before the mode command that uses it.
      cnt = 32'h1 + ($unsigned($random(seed)) % 4);
      bus(1'b1, TLPT_OFS_PDUCNT, cnt, rd);
      cmd(TLPT_CMD_TEST_MODE, 2'b00);
      `CHK(tbf_req, 1'b1)
      `CHK(llc_pass, 1'b0)
      chk_state(3'h3);
      cmd(TLPT_CMD_TBF_GRANT, 2'b00);
      chk_state(3'h4);
      tn = 3'($random(seed));
      sim.ask_ul(40, tn);
      prbs_check();
      sim.pdus(int'(cnt));
      chk_state(3'h0);
      `CHK(llc_pass, 1'b1)
      bus(1'b0, TLPT_OFS_SENT, 32'h0, rd);
      `CHK(rd, cnt)
      // A new mode command is only sent once the last mode has ended.
      foreach (rels[j]) begin
         cmd(TLPT_CMD_TEST_MODE, 2'b10);
         cmd(TLPT_CMD_TBF_GRANT, 2'b00);
         chk_state(3'h5);
         n = 8 + ($unsigned($random(seed)) % 8);
         sim.send_dl(n, 3'h0);
         sim.ask_ul(1, 3'h0);
         `CHK(sim.uq[0].data_bit, sim.dq[n-8])
         `CHK(sim.uq[0].cv, TLPT_CV_HOLD)
         `CHK(llc_pass, 1'b0)
         sim.uq.delete();
         cmd(rels[j], 2'b00);
         chk_state(3'h0);
      end
      bus(1'b0, TLPT_OFS_EVENT, 32'h0, rd);
      `CHK(rd & 32'h30, 32'h30)
      print_verdict();
   end

endmodule : tlpt_ctrl_bench
